/* File: indirect_address_word_walker.sv */
// Channel data address walker with indirect address list support.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Forward block boundary is bits 0-10 rolling from all ones to zeros.
// - At a boundary the next list word is fetched and transfer resumes there.
// - List words are fetched only when their boundary is reached, never ahead.
// - Walking continues until count reaches zero, the tape gap ends it or a bad list word raises program check.
// - On chaining the next command is fetched and its indirect flag tested.
// - Flag clear: bits 32-55 are buffer start; set: list address.
// - List words: bits 24-31 zero; later words start a block (end one when backward), else program check.
// - Transfer starts at first list word address and steps through block.
module idadw_walker
  import idadw_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // Start of a channel program
  input  wire logic              start,
  input  wire logic [ADDR_W-1:0] first_cmd_addr,
  // Storage fetch port for commands and list words
  output logic                   fetch_req,
  output logic [ADDR_W-1:0]      fetch_addr,
  output logic                   fetch_cmd,
  input  wire logic              fetch_ack,
  input  wire logic [CMD_W-1:0]  fetch_data,
  // Data transfer with the control unit
  output logic                   data_valid,
  output logic [ADDR_W-1:0]      data_addr,
  output logic                   data_backward,
  input  wire logic              data_ack,
  input  wire logic              tape_record_gap,
  // Status
  output logic                   busy,
  output logic                   done,
  output logic                   program_check
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    idadw_state_t      state;
    logic [ADDR_W-1:0] cmd_ptr;
    logic [ADDR_W-1:0] list_ptr;
    logic [ADDR_W-1:0] addr;
    logic [COUNT_W-1:0] count;
    logic              indirect_flag;
    logic              backward;
    logic              chain;
    logic              first_word;
    logic              fetch_req;
    logic              fetch_cmd;
    logic              data_valid;
    logic              done;
    logic              program_check;
    logic [ADDR_W-1:0] fetch_addr;
    logic              busy;
  } idadw_regs_t;

  idadw_regs_t cur;
  idadw_regs_t next_cur;
  logic        at_edge;

  // Command word fields: flag, direction, chain, count and address.
  logic [ADDR_W-1:0]  cmd_addr;
  logic [COUNT_W-1:0] cmd_count;
  logic               cmd_ind;
  logic               cmd_back;
  logic               cmd_chain;
  logic [ADDR_W-1:0]  word_addr;
  logic               word_bad;

  assign cmd_addr  = fetch_data[CMD_ADDR_LSB+ADDR_W-1:CMD_ADDR_LSB];
  assign cmd_ind   = fetch_data[CMD_IND_BIT];
  assign cmd_back  = fetch_data[CMD_IND_BIT+1];
  assign cmd_chain = fetch_data[CMD_IND_BIT+2];
  assign cmd_count = fetch_data[COUNT_W-1:0];
  assign word_addr = fetch_data[ADDR_W-1:0];

  // Later words must start a block, or end one when running backward.
  always_comb begin
    word_bad = (fetch_data[ADDR_W+WORD_TOP_W-1:ADDR_W] != '0);
    if (!cur.first_word) begin
      if (cur.backward) begin
        word_bad = word_bad | (word_addr[BLOCK_W-1:0] != BLOCK_ONES);
      end else begin
        word_bad = word_bad | (word_addr[BLOCK_W-1:0] != BLOCK_ZEROS);
      end
    end
  end

  idadw_bound u_bound (
    .addr     (cur.addr),
    .backward (cur.backward),
    .at_edge  (at_edge)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    unique case (cur.state)
      IDADW_IDLE: begin
        if (start) begin
          next_cur.cmd_ptr       = first_cmd_addr;
          next_cur.program_check = 1'b0;
          next_cur.fetch_req     = 1'b1;
          next_cur.fetch_cmd     = 1'b1;
          next_cur.state         = IDADW_CMD_FETCH;
        end
      end
      IDADW_CMD_FETCH: begin
        if (fetch_ack) begin
          next_cur.fetch_req     = 1'b0;
          next_cur.cmd_ptr       = cur.cmd_ptr + ADDR_W'(CMD_W / 8);
          next_cur.indirect_flag = cmd_ind;
          next_cur.backward      = cmd_back;
          next_cur.chain         = cmd_chain;
          next_cur.count         = cmd_count;
          next_cur.first_word    = 1'b1;
          if (cmd_ind) begin
            // The command points at the list; fetch its first word.
            next_cur.list_ptr  = cmd_addr;
            next_cur.fetch_req = 1'b1;
            next_cur.fetch_cmd = 1'b0;
            next_cur.state     = IDADW_WORD_FETCH;
          end else begin
            next_cur.addr       = cmd_addr;
            next_cur.data_valid = 1'b1;
            next_cur.state      = IDADW_XFER;
          end
          if (cmd_count == '0) begin
            next_cur.fetch_req  = 1'b0;
            next_cur.data_valid = 1'b0;
            next_cur.state      = IDADW_DONE;
          end
        end
      end
      IDADW_WORD_FETCH: begin
        if (fetch_ack) begin
          next_cur.fetch_req  = 1'b0;
          next_cur.first_word = 1'b0;
          if (word_bad || cur.list_ptr[1:0] != WORD_ALIGN) begin
            next_cur.program_check = 1'b1;
            next_cur.chain         = 1'b0;
            next_cur.state         = IDADW_DONE;
          end else begin
            next_cur.list_ptr   = cur.list_ptr + WORD_STEP;
            next_cur.addr       = word_addr;
            next_cur.data_valid = 1'b1;
            next_cur.state      = IDADW_XFER;
          end
        end
      end
      IDADW_XFER: begin
        if (tape_record_gap) begin
          next_cur.data_valid = 1'b0;
          next_cur.state      = IDADW_DONE;
        end else if (data_ack) begin
          next_cur.count = cur.count - COUNT_ONE;
          if (cur.backward) begin
            next_cur.addr = cur.addr - BYTE_STEP;
          end else begin
            next_cur.addr = cur.addr + BYTE_STEP;
          end
          if (cur.count == COUNT_ONE) begin
            next_cur.data_valid = 1'b0;
            next_cur.state      = IDADW_DONE;
          end else if (cur.indirect_flag && at_edge) begin
            // Only now is the next word needed, so only now is it read.
            next_cur.data_valid = 1'b0;
            next_cur.fetch_req  = 1'b1;
            next_cur.fetch_cmd  = 1'b0;
            next_cur.state      = IDADW_WORD_FETCH;
          end
        end
      end
      IDADW_DONE: begin
        if (cur.chain) begin
          next_cur.fetch_req = 1'b1;
          next_cur.fetch_cmd = 1'b1;
          next_cur.state     = IDADW_CMD_FETCH;
        end else begin
          next_cur.done  = 1'b1;
          next_cur.state = IDADW_IDLE;
        end
      end
    endcase
    // Address and busy are kept as registered copies so no output leaves a mux or decode.
    next_cur.busy       = (next_cur.state != IDADW_IDLE);
    next_cur.fetch_addr = next_cur.fetch_cmd ? next_cur.cmd_ptr : next_cur.list_ptr;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cur       <= '0;
      cur.state <= IDADW_IDLE;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign fetch_req     = cur.fetch_req;
  assign fetch_cmd     = cur.fetch_cmd;
  assign fetch_addr    = cur.fetch_addr;
  assign data_valid    = cur.data_valid;
  assign data_addr     = cur.addr;
  assign data_backward = cur.backward;
  assign busy          = cur.busy;
  assign done          = cur.done;
  assign program_check = cur.program_check;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence edge_step_s;
    data_valid && data_ack && !tape_record_gap && cur.indirect_flag && at_edge
      && cur.count != COUNT_ONE;
  endsequence

  fwd_edge_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    edge_step_s and !data_backward |=> fetch_req && !fetch_cmd
      && data_addr[BLOCK_W-1:0] == BLOCK_ZEROS)
    else $error("forward boundary did not fetch next word");

  back_edge_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    edge_step_s and data_backward |=> fetch_req && data_addr[BLOCK_W-1:0] == BLOCK_ONES)
    else $error("backward boundary did not fetch next word");

  no_prefetch_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    fetch_req && !fetch_cmd |-> !data_valid)
    else $error("list word read while transfer running");

  resume_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cur.state == IDADW_WORD_FETCH && fetch_ack && !word_bad && fetch_addr[1:0] == WORD_ALIGN
      |=> data_valid && data_addr == $past(word_addr))
    else $error("transfer did not resume at list word address");

  count_end_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    data_valid && data_ack && cur.count == COUNT_ONE
      |=> !data_valid ##1 (done || (fetch_req && fetch_cmd)))
    else $error("transfer ran past zero count");

  gap_end_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    data_valid && tape_record_gap |=> !data_valid)
    else $error("transfer ran past tape gap");

  chain_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cur.state == IDADW_DONE && cur.chain |=> fetch_req && fetch_cmd)
    else $error("chaining did not fetch next command");

  direct_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cur.state == IDADW_CMD_FETCH && fetch_ack && !cmd_ind && cmd_count != '0
      |=> data_valid && data_addr == $past(cmd_addr))
    else $error("direct command did not start at its address");

  bad_word_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cur.state == IDADW_WORD_FETCH && fetch_ack && word_bad |=> program_check && !data_valid)
    else $error("misaligned list word not flagged");

  step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    data_valid && data_ack && !tape_record_gap && !data_backward
      |=> data_addr == $past(data_addr) + BYTE_STEP)
    else $error("forward address did not ascend");

endmodule

`default_nettype wire

/* File: indirect_address_word_pkg.sv */
// Package of constants and types for the indirect data address walker.
package idadw_pkg;

  // ----------------------------------------------------------------------
  // Word layouts
  // ----------------------------------------------------------------------
  localparam int ADDR_W          = 24;
  localparam int CMD_W           = 64;
  localparam int CMD_ADDR_LSB    = 32;
  localparam int CMD_IND_BIT     = 26;
  localparam int COUNT_W         = 16;
  localparam int WORD_TOP_W      = 8;
  localparam int BLOCK_W         = 11;
  localparam logic [BLOCK_W-1:0] BLOCK_ONES  = 11'h7ff;
  localparam logic [BLOCK_W-1:0] BLOCK_ZEROS = 11'h000;
  localparam logic [ADDR_W-1:0]  WORD_STEP   = 24'h000004;
  localparam logic [ADDR_W-1:0]  BYTE_STEP   = 24'h000001;
  localparam logic [ADDR_W-1:0]  ADDR_ZERO   = 24'h000000;
  localparam logic [1:0]         WORD_ALIGN  = 2'h0;
  localparam logic [COUNT_W-1:0] COUNT_ONE   = 16'h0001;

  typedef enum logic [2:0] {
    IDADW_IDLE,
    IDADW_CMD_FETCH,
    IDADW_WORD_FETCH,
    IDADW_XFER,
    IDADW_DONE
  } idadw_state_t;

endpackage

/* File: indirect_address_word_bound.sv */
// Block boundary detector for the transfer address.
`timescale 1ns/1ps
`default_nettype none

module idadw_bound
  import idadw_pkg::*;
(
  // Current address and direction
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              backward,
  // Result
  output logic                   at_edge
);

  // The last byte of a block is the one whose step crosses the boundary.
  always_comb begin
    if (backward) begin
      at_edge = (addr[BLOCK_W-1:0] == BLOCK_ZEROS);
    end else begin
      at_edge = (addr[BLOCK_W-1:0] == BLOCK_ONES);
    end
  end

endmodule

`default_nettype wire

/* File: idadw_store_model.sv */
// Main storage and control unit model facing the walker.
`timescale 1ns/1ps
`default_nettype none

module idadw_store_model
  import idadw_pkg::*;
(
  // Clock
  input  wire logic              sys_clk,
  // Storage fetch port
  input  wire logic              fetch_req,
  input  wire logic [ADDR_W-1:0] fetch_addr,
  input  wire logic              fetch_cmd,
  output logic                   fetch_ack,
  output logic [CMD_W-1:0]       fetch_data,
  // Control unit side
  input  wire logic              data_valid,
  input  wire logic [ADDR_W-1:0] data_addr,
  input  wire logic              data_backward,
  output logic                   data_ack,
  output logic                   tape_record_gap,
  // Pace and record gap controls
  input  wire logic              slow,
  input  wire logic [15:0]       gap_after
);
  logic [CMD_W-1:0] cmd_mem [logic [ADDR_W-1:0]];
  logic [31:0]      word_mem [logic [ADDR_W-1:0]];
  logic [25:0]      log_q [$];
  int               lat = 0;
  int               n_bytes = 0;

  initial begin
    fetch_ack = 1'b0;
    fetch_data = '0;
    data_ack = 1'b0;
    tape_record_gap = 1'b0;
  end

  // ----------------------------------------------------------------------
  // Log of every taken fetch and byte, in the order the walker made them
  // ----------------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (fetch_req && fetch_ack) begin
      log_q.push_back({fetch_cmd ? 2'h2 : 2'h1, fetch_addr});
    end
    if (fetch_req && !fetch_ack && lat >= (slow ? 3 : 0)) begin
      fetch_ack <= #1 1'b1;
      fetch_data <= #1 fetch_cmd ? cmd_mem[fetch_addr] : {32'h0, word_mem[fetch_addr]};
      lat <= 0;
    end else begin
      fetch_ack <= #1 1'b0;
      // Outside the answer cycle the bus never keeps the last value.
      fetch_data <= #1 ~fetch_data;
      lat <= (fetch_req && !fetch_ack) ? lat + 1 : 0;
    end
    // The walker gives the record gap priority, so a byte acked under it is not moved.
    if (data_valid && data_ack && !tape_record_gap) begin
      log_q.push_back({data_backward, data_backward, data_addr});
      n_bytes++;
    end
    data_ack <= #1 data_valid && !(slow && data_ack);
    tape_record_gap <= #1 (n_bytes >= gap_after);
  end
endmodule
`default_nettype wire

/* File: indirect_data_address_walker_tb.sv */
// Self-checking testbench of the indirect data address walker.
`timescale 1ns/1ps
`default_nettype none

module indirect_data_address_walker_tb
  import idadw_pkg::*;
;
  logic              sys_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              start = 1'b0;
  logic [ADDR_W-1:0] first_cmd_addr = '0;
  logic              slow = 1'b0;
  logic [15:0]       gap_after = 16'hffff;
  logic              fetch_req, fetch_cmd, fetch_ack, data_valid, data_backward, data_ack;
  logic              tape_record_gap, busy, done, program_check;
  logic [ADDR_W-1:0] fetch_addr, data_addr;
  logic [CMD_W-1:0]  fetch_data;
  logic [25:0]       exp_q [$];
  int                n_errors = 0;
  int                tests_run = 0;

  always #12.5 sys_clk = ~sys_clk;

  idadw_walker idadw_walker_i (.sys_clk, .rst_n, .start, .first_cmd_addr, .fetch_req,
    .fetch_addr, .fetch_cmd, .fetch_ack, .fetch_data, .data_valid, .data_addr, .data_backward,
    .data_ack,
    .tape_record_gap, .busy, .done, .program_check);
  idadw_store_model store_i (.sys_clk, .fetch_req, .fetch_addr, .fetch_cmd, .fetch_ack,
    .fetch_data, .data_valid, .data_addr, .data_backward, .data_ack, .tape_record_gap, .slow,
    .gap_after);

  // ----------------------------------------------------------------------
  // Compare, expectation and run helpers
  // ----------------------------------------------------------------------
  task automatic check_ent(input string what, input logic [25:0] exp, input logic [25:0] got);
    tests_run++;
    if (exp !== got) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_flag(input string what, input logic exp, input logic got);
    tests_run++;
    if (exp !== got) begin
      n_errors++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic logic [CMD_W-1:0] cmd(input logic [23:0] a, input logic ch, bk, ind,
                                           input logic [15:0] n);
    return {8'h00, a, 3'h0, ch, bk, ind, 10'h000, n};
  endfunction

  task automatic expect_bytes(input logic [23:0] a, input int n, input logic bk);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back({bk, bk, bk ? a - 24'(i) : a + 24'(i)});
    end
  endtask

  // Starts a program, tries a second start while busy, then judges the log.
  task automatic run(input logic [23:0] a, input logic exp_chk, input logic exact);
    int t;
    store_i.log_q.delete();
    store_i.n_bytes = 0;
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      #1 start = 1'b1;
      first_cmd_addr = k ? 24'h000f00 : a;
      @(posedge sys_clk);
      #1 start = 1'b0;
      @(negedge sys_clk);
      check_flag("busy", 1'b1, busy);
    end
    t = 0;
    while (done !== 1'b1 && t < 20000) begin
      @(negedge sys_clk);
      t++;
    end
    check_flag("done", 1'b1, done);
    check_flag("program_check", exp_chk, program_check);
    @(negedge sys_clk);
    check_flag("busy_end", 1'b0, busy);
    for (int i = 0; i < exp_q.size(); i++) begin
      check_ent("log", exp_q[i], i < store_i.log_q.size() ? store_i.log_q[i] : 26'h3ffffff);
    end
    if (exact) begin
      check_ent("log_len", 26'(exp_q.size()), 26'(store_i.log_q.size()));
    end else begin
      check_flag("log_short", 1'b1, store_i.log_q.size() <= exp_q.size() + 1);
    end
    exp_q.delete();
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic direct_count();
    store_i.cmd_mem[24'h0000c0] = cmd(24'h000100, 1'b0, 1'b0, 1'b0, 16'h0004);
    exp_q.push_back({2'h2, 24'h0000c0});
    expect_bytes(24'h000100, 4, 1'b0);
    run(24'h0000c0, 1'b0, 1'b1);
  endtask

  task automatic forward_chain();
    store_i.cmd_mem[24'h000200] = cmd(24'h001000, 1'b1, 1'b0, 1'b1, 16'h0006);
    store_i.cmd_mem[24'h000208] = cmd(24'h000300, 1'b0, 1'b0, 1'b0, 16'h0002);
    store_i.word_mem[24'h001000] = 32'h000007fd;
    store_i.word_mem[24'h001004] = 32'h00005000;
    exp_q = '{{2'h2, 24'h000200}, {2'h1, 24'h001000}};
    expect_bytes(24'h0007fd, 3, 1'b0);
    exp_q.push_back({2'h1, 24'h001004});
    expect_bytes(24'h005000, 3, 1'b0);
    exp_q.push_back({2'h2, 24'h000208});
    expect_bytes(24'h000300, 2, 1'b0);
    run(24'h000200, 1'b0, 1'b1);
  endtask

  task automatic backward_slow();
    slow = 1'b1;
    store_i.cmd_mem[24'h000400] = cmd(24'h001100, 1'b0, 1'b1, 1'b1, 16'h0005);
    store_i.word_mem[24'h001100] = 32'h00000802;
    store_i.word_mem[24'h001104] = 32'h000017ff;
    exp_q = '{{2'h2, 24'h000400}, {2'h1, 24'h001100}};
    expect_bytes(24'h000802, 3, 1'b1);
    exp_q.push_back({2'h1, 24'h001104});
    expect_bytes(24'h0017ff, 2, 1'b1);
    run(24'h000400, 1'b0, 1'b1);
    slow = 1'b0;
  endtask

  // A misplaced later word and a nonzero top byte both stop the chain.
  task automatic bad_words();
    for (int k = 0; k < 2; k++) begin
      store_i.cmd_mem[24'h000500] = cmd(24'h001200, 1'b1, 1'b0, 1'b1, 16'h0004);
      store_i.cmd_mem[24'h000508] = cmd(24'h000300, 1'b0, 1'b0, 1'b0, 16'h0002);
      store_i.word_mem[24'h001200] = k ? 32'h010007fe : 32'h000007fe;
      store_i.word_mem[24'h001204] = 32'h00005010;
      exp_q = '{{2'h2, 24'h000500}, {2'h1, 24'h001200}};
      if (k == 0) begin
        expect_bytes(24'h0007fe, 2, 1'b0);
        exp_q.push_back({2'h1, 24'h001204});
      end
      run(24'h000500, 1'b1, 1'b1);
    end
  endtask

  task automatic record_gap();
    gap_after = 16'h0003;
    store_i.cmd_mem[24'h000700] = cmd(24'h002000, 1'b0, 1'b0, 1'b0, 16'h000a);
    exp_q.push_back({2'h2, 24'h000700});
    expect_bytes(24'h002000, 3, 1'b0);
    run(24'h000700, 1'b0, 1'b1);
    gap_after = 16'hffff;
  endtask

  initial begin
    #(25ns * 40000);
    n_errors++;
    print_verdict();
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    @(negedge sys_clk);
    check_flag("reset_busy", 1'b0, busy);
    direct_count();
    forward_chain();
    backward_slow();
    bad_words();
    record_gap();
    print_verdict();
  end
endmodule
`default_nettype wire
